// *** irdp_bank.sv ***
// Operation
// - bit 31 of target register is a read-only ready flag, one after reset
// - ready reads one when idle, zero while a ram access runs
// - on reads ready returns only after the word lands in the data register
// - bits 3:0 pick the ram; codes 0..5 and 7 valid, others reserved
// - a write to command bit 0 while ready starts an access; one writes, zero reads
// - 14-bit word address in bits 13:0, upper bits read zero
// - 32-bit data register supplies write data and receives read data
module irdp_bank
  import irdp_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     clk_en,
  input  wire logic [7:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  output logic [7:0]                    ram_req,
  output logic                          ram_wr,
  output logic [IRDP_ADDR_W-1:0]        ram_addr,
  output logic [IRDP_DATA_W-1:0]        ram_wdata,
  input  wire logic [7:0]               ram_ack,
  input  wire logic [8*IRDP_DATA_W-1:0] ram_rdata
);
  typedef struct packed {
    irdp_state_type         state;
    logic [IRDP_TGT_W-1:0]  tgt;
    logic                   cmd;
    // direction latched at launch, so a late command write cannot turn a running access around
    logic                   op_wr;
    logic [IRDP_ADDR_W-1:0] addr;
    logic [IRDP_DATA_W-1:0] data;
    logic [31:0]            rdata;
    logic                   ack;
  } irdp_regs_type;

  irdp_regs_type st_reg;
  irdp_regs_type st_next;
  irdp_ram_if    rif ();
  logic          ready;
  logic          wr_hit;
  logic          rd_hit;
  logic [31:0]   wmask;

  ////////////////////////////////////////////////////////////////////////////
  // ram mux

  irdp_ram_mux u_mux (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .bus       (rif),
    .ram_req   (ram_req),
    .ram_wr    (ram_wr),
    .ram_addr  (ram_addr),
    .ram_wdata (ram_wdata),
    .ram_ack   (ram_ack),
    .ram_rdata (ram_rdata)
  );

  // data register drives the write word
  assign rif.req   = (st_reg.state == IRDP_REQ);
  assign rif.wr    = st_reg.op_wr;
  assign rif.tgt   = st_reg.tgt;
  assign rif.addr  = st_reg.addr;
  assign rif.wdata = st_reg.data;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state per access, answer on the second edge

  assign ready           = (st_reg.state == IRDP_IDLE);
  assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
  assign avs_readdata    = st_reg.rdata;
  assign wr_hit          = avs_write && !st_reg.ack && clk_en;
  assign rd_hit          = avs_read && !st_reg.ack && clk_en;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // next-state of the whole bank
  always_comb begin
    st_next     = st_reg;
    st_next.ack = 1'b0;
    if (rd_hit) begin
      st_next.ack = 1'b1;
      unique case (avs_address)
        IRDP_OFF_SEL:  st_next.rdata = {ready, 27'h0, st_reg.tgt};
        IRDP_OFF_CMD:  st_next.rdata = {31'h0, st_reg.cmd};
        IRDP_OFF_ADDR: st_next.rdata = {18'h0, st_reg.addr};
        IRDP_OFF_DATA: st_next.rdata = st_reg.data;
        default:       st_next.rdata = IRDP_UNMAPPED;
      endcase
    end
    if (wr_hit) begin
      st_next.ack = 1'b1;
      unique case (avs_address)
        IRDP_OFF_SEL: begin
          if (avs_byteenable[0]) begin
            st_next.tgt = avs_writedata[IRDP_TGT_W-1:0];
          end
        end
        IRDP_OFF_CMD: begin
          if (avs_byteenable[0]) begin
            st_next.cmd = avs_writedata[0];
            // busy from next clock; commands while busy only store the command bit
            if (ready) begin
              st_next.state = IRDP_REQ;
              st_next.op_wr = avs_writedata[0];
            end
          end
        end
        IRDP_OFF_ADDR: begin
          st_next.addr = (st_reg.addr & ~wmask[IRDP_ADDR_W-1:0]) |
                         (avs_writedata[IRDP_ADDR_W-1:0] & wmask[IRDP_ADDR_W-1:0]);
        end
        IRDP_OFF_DATA: begin
          st_next.data = (st_reg.data & ~wmask) | (avs_writedata & wmask);
        end
        default: begin
          st_next.data = st_reg.data;
        end
      endcase
    end
    // access sequencing
    if (clk_en) begin
      unique case (st_reg.state)
        IRDP_IDLE: begin
          st_next.state = st_next.state;
        end
        IRDP_REQ: begin
          if (rif.done) begin
            // read word captured before ready returns
            if (!st_reg.op_wr) begin
              st_next.data = rif.rdata;
            end
            st_next.state = IRDP_WAIT;
          end
        end
        IRDP_WAIT: begin
          st_next.state = IRDP_IDLE;
        end
        default: begin
          st_next.state = IRDP_IDLE;
        end
      endcase
    end
  end

  // state register; clock enable freezes everything but reset, which loads even with clock enable low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg.state <= IRDP_IDLE;
      st_reg.tgt   <= IRDP_TGT_RST;
      st_reg.cmd   <= IRDP_CMD_RST;
      st_reg.op_wr <= IRDP_CMD_RST;
      st_reg.addr  <= IRDP_ADDR_RST;
      st_reg.data  <= IRDP_DATA_RST;
      st_reg.rdata <= IRDP_UNMAPPED;
      st_reg.ack   <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  reset_ready_a: assert property (@(posedge core_clk)
    $fell(rst) |-> ready) else $error("ready low after reset");
  busy_after_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && wr_hit && avs_address == IRDP_OFF_CMD && avs_byteenable[0] && ready
    |=> !ready) else $error("ready not cleared after command");
  // read data stored the cycle after the ram answers
  read_capture_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && rif.req && rif.done && !st_reg.op_wr |=> st_reg.data == $past(rif.rdata))
    else $error("read word not captured");
  // flag read while busy shows zero
  busy_during_req_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.ack && $past(rd_hit) && $past(avs_address) == IRDP_OFF_SEL && !$past(ready)
    |-> !avs_readdata[31]) else $error("ready high during access");
  addr_upper_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.ack && $past(avs_read) && $past(avs_address) == IRDP_OFF_ADDR
    |-> avs_readdata[31:14] == 18'h0) else $error("address upper bits nonzero");
  cmd_store_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && wr_hit && avs_address == IRDP_OFF_CMD && avs_byteenable[0]
    |=> st_reg.cmd == $past(avs_writedata[0])) else $error("command bit not stored");
  tgt_store_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && wr_hit && avs_address == IRDP_OFF_SEL && avs_byteenable[0]
    |=> st_reg.tgt == $past(avs_writedata[3:0])) else $error("target not stored");
  write_data_a: assert property (@(posedge core_clk) disable iff (rst)
    rif.req && st_reg.op_wr |-> ram_wdata == st_reg.data && ram_wr) else $error("write word wrong");
  // bus answers in one wait state
  bus_answer_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && (avs_read || avs_write) && avs_waitrequest ##1 clk_en |-> !avs_waitrequest)
    else $error("bus answer late");
  launch_dir_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && wr_hit && avs_address == IRDP_OFF_CMD && avs_byteenable[0] && ready
    |=> rif.req && ram_wr == $past(avs_writedata[0])) else $error("access direction wrong");
  idle_no_req_a: assert property (@(posedge core_clk) disable iff (rst)
    ready |-> ram_req == 8'h00) else $error("ram strobe while idle");
  wait_ready_a: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && st_reg.state == IRDP_WAIT |=> ready) else $error("ready not restored");
endmodule : irdp_bank

// *** irdp_bank_test.sv ***
module irdp_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irdp_pkg::*;
  typedef struct {logic [3:0] tgt; logic wr; int lat; logic [13:0] addr; logic [31:0] data;
                  logic [7:0] req; logic [31:0] exp;} irdp_row_type;
  logic                         core_clk = 1'b0;
  logic                         rst, clk_en, avs_read, avs_write, avs_waitrequest, ram_wr, got_wr;
  logic [7:0]                   avs_address, ram_req, ram_ack, got_req;
  logic [31:0]                  avs_writedata, avs_readdata, ram_wdata, got_wdata, first, rd;
  logic [3:0]                   avs_byteenable;
  logic [IRDP_ADDR_W-1:0]       ram_addr, got_addr;
  logic [8*IRDP_DATA_W-1:0]     ram_rdata;
  int                           mismatches = 0, tests_run = 0, lat = 5, cnt = 0, acc_count = 0, c0;
  irdp_row_type                 rows[10] = '{
    '{4'h1, 1'b1, 5, 14'h0123, 32'hdead_beef, 8'h02, 32'hdead_beef},
    '{4'h1, 1'b0, 5, 14'h0123, 32'h0000_0000, 8'h02, 32'h1000_0123},
    '{4'h0, 1'b0, 0, 14'h3fff, 32'h0000_0000, 8'h01, 32'h0000_3fff},
    '{4'h2, 1'b1, 5, 14'h0001, 32'h1234_5678, 8'h04, 32'h1234_5678},
    '{4'h3, 1'b0, 5, 14'h0002, 32'h0000_0000, 8'h08, 32'h3000_0002},
    '{4'h4, 1'b1, 5, 14'h0004, 32'hcafe_0004, 8'h10, 32'hcafe_0004},
    '{4'h5, 1'b0, 5, 14'h2000, 32'h0000_0000, 8'h20, 32'h5000_2000},
    '{4'h7, 1'b0, 5, 14'h0007, 32'h0000_0000, 8'h80, 32'h7000_0007},
    '{4'h6, 1'b0, 5, 14'h0006, 32'h5555_aaaa, 8'h00, 32'h0000_0000},
    '{4'hf, 1'b0, 5, 14'h000f, 32'h5555_aaaa, 8'h00, 32'h0000_0000}};

  irdp_bank irdp_bank_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ram_req(ram_req), .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack),
    .ram_rdata(ram_rdata));

  // clock: 8 ns period
  always #4 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  // ram stand-in: acks lat+1 cycles after the request appears, never twice for one request
  always @(posedge core_clk) begin
    ram_ack <= 8'h00;
    if (ram_req == 8'h00 || ram_ack != 8'h00) begin
      cnt <= 0;
    end else if (cnt >= lat) begin
      ram_ack   <= ram_req;
      got_req   <= ram_req;
      got_wr    <= ram_wr;
      got_addr  <= ram_addr;
      got_wdata <= ram_wdata;
      acc_count <= acc_count + 1;
      cnt       <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // each ram answers with its own code and the word address, so a wrong route shows
  always_comb begin
    for (int n = 0; n < 8; n++) ram_rdata[32*n +: 32] = {4'(n), 14'h0000, ram_addr};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one avalon transfer; request held until waitrequest is sampled low at a rising edge,
  // read data taken at that same edge; only the watchdog ends a stuck wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ready polled first: until the flag is back; first poll is kept
  task automatic wait_ready();
    int n;
    n = 0;
    bus(1'b0, IRDP_OFF_SEL, 32'h0, first);
    rd = first;
    while (rd[IRDP_READY_BIT] !== 1'b1 && n < 60) begin
      bus(1'b0, IRDP_OFF_SEL, 32'h0, rd);
      n++;
    end
    if (n >= 60) mismatches++;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; clk_en = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00;
    avs_writedata = 32'h0; avs_byteenable = 4'hf; ram_ack = 8'h00;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // every ram reached: the bench plays configuration time, not run time
    foreach (rows[i]) begin
      lat = rows[i].lat;
      bus(1'b1, IRDP_OFF_SEL, {28'h0, rows[i].tgt}, rd);
      // address and data before the command
      bus(1'b1, IRDP_OFF_ADDR, {18'h0, rows[i].addr}, rd);
      bus(1'b1, IRDP_OFF_DATA, rows[i].data, rd);
      c0 = acc_count;
      bus(1'b1, IRDP_OFF_CMD, {31'h0, rows[i].wr}, rd);
      wait_ready();
      if (rows[i].req != 8'h00 && rows[i].lat > 0) check("ready while busy", {31'h0, first[31]}, 32'h0);
      check("access count", acc_count - c0, (rows[i].req != 8'h00) ? 32'h1 : 32'h0);
      if (rows[i].req != 8'h00) begin
        check("ram select", {24'h0, got_req}, {24'h0, rows[i].req});
        check("ram direction", {31'h0, got_wr}, {31'h0, rows[i].wr});
        check("ram address", {18'h0, got_addr}, {18'h0, rows[i].addr});
        if (rows[i].wr) check("ram write word", got_wdata, rows[i].data);
      end
      check("target readback", rd, {1'b1, 27'h0, rows[i].tgt});
      bus(1'b0, IRDP_OFF_DATA, 32'h0, rd);
      check("data register", rd, rows[i].exp);
    end
    // read-only and reserved bits, unmapped offset
    bus(1'b1, IRDP_OFF_SEL, 32'hffff_fff1, rd);
    bus(1'b0, IRDP_OFF_SEL, 32'h0, rd);
    check("target masks", rd, 32'h8000_0001);
    bus(1'b1, IRDP_OFF_ADDR, 32'hffff_ffff, rd);
    bus(1'b0, IRDP_OFF_ADDR, 32'h0, rd);
    check("address masks", rd, 32'h0000_3fff);
    bus(1'b1, 8'h34, 32'h1111_2222, rd);
    bus(1'b0, 8'h34, 32'h0, rd);
    check("unmapped read", rd, IRDP_UNMAPPED);
    // clock enable low freezes the bank: a write stalls and lands once it is high again
    clk_en <= 1'b0;
    fork
      bus(1'b1, IRDP_OFF_ADDR, 32'h0000_0155, rd);
      begin
        repeat (6) @(posedge core_clk);
        check("frozen bus wait", {31'h0, avs_waitrequest}, 32'h1);
        clk_en <= 1'b1;
      end
    join
    bus(1'b0, IRDP_OFF_ADDR, 32'h0, rd);
    check("frozen write lands", rd, 32'h0000_0155);
    // a command written while busy is stored but starts nothing
    lat = 20;
    c0 = acc_count;
    bus(1'b1, IRDP_OFF_CMD, 32'h0, rd);
    bus(1'b1, IRDP_OFF_CMD, 32'h1, rd);
    wait_ready();
    check("busy command count", acc_count - c0, 32'h1);
    check("busy command kind", {31'h0, got_wr}, 32'h0);
    bus(1'b0, IRDP_OFF_CMD, 32'h0, rd);
    check("command readback", rd, 32'h1);
    // second reset lands in the middle of a write access
    c0 = acc_count;
    bus(1'b1, IRDP_OFF_CMD, 32'h1, rd);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, IRDP_OFF_SEL, 32'h0, rd);
    check("target reset", rd, {IRDP_READY_RST, 27'h0, IRDP_TGT_RST});
    check("reset drops access", acc_count - c0, 32'h0);
    bus(1'b0, IRDP_OFF_CMD, 32'h0, rd);
    check("command reset", rd, 32'h0);
    bus(1'b0, IRDP_OFF_ADDR, 32'h0, rd);
    check("address reset", rd, 32'h0);
    bus(1'b0, IRDP_OFF_DATA, 32'h0, rd);
    check("data reset", rd, 32'h0);
    tally_and_finish();
  end
endmodule // irdp_bank_test

// *** irdp_pkg.sv ***
package irdp_pkg;
  // register byte offsets
  localparam logic [7:0] IRDP_OFF_SEL  = 8'h24;
  localparam logic [7:0] IRDP_OFF_CMD  = 8'h28;
  localparam logic [7:0] IRDP_OFF_ADDR = 8'h2c;
  localparam logic [7:0] IRDP_OFF_DATA = 8'h30;
  // field positions and widths
  localparam int IRDP_READY_BIT = 31;
  localparam int IRDP_TGT_W     = 4;
  localparam int IRDP_ADDR_W    = 14;
  localparam int IRDP_DATA_W    = 32;
  // reset values
  localparam logic                   IRDP_READY_RST = 1'b1;
  localparam logic [IRDP_TGT_W-1:0]  IRDP_TGT_RST   = 4'h0;
  localparam logic                   IRDP_CMD_RST   = 1'b0;
  localparam logic [IRDP_ADDR_W-1:0] IRDP_ADDR_RST  = 14'h0000;
  localparam logic [IRDP_DATA_W-1:0] IRDP_DATA_RST  = 32'h0000_0000;
  // ram target codes
  localparam logic [3:0] IRDP_TGT_USB_RX    = 4'h0;
  localparam logic [3:0] IRDP_TGT_VLAN_HASH = 4'h1;
  localparam logic [3:0] IRDP_TGT_HDR  = 4'h2;
  localparam logic [3:0] IRDP_TGT_FCRX = 4'h3;
  localparam logic [3:0] IRDP_TGT_FCTX = 4'h4;
  localparam logic [3:0] IRDP_TGT_DESC = 4'h5;
  localparam logic [3:0] IRDP_TGT_USB_TX = 4'h7;
  // value returned for unmapped offsets and reserved targets
  localparam logic [31:0] IRDP_UNMAPPED = 32'h0000_0000;
  // port state machine
  typedef enum logic [2:0] {
    IRDP_IDLE = 3'b001,
    IRDP_REQ  = 3'b010,
    IRDP_WAIT = 3'b100
  } irdp_state_type;
endpackage : irdp_pkg

// *** irdp_ram_if.sv ***
// request and answer between the register bank and the ram mux
interface irdp_ram_if;
  import irdp_pkg::*;
  logic                   req;
  logic                   wr;
  logic [IRDP_TGT_W-1:0]  tgt;
  logic [IRDP_ADDR_W-1:0] addr;
  logic [IRDP_DATA_W-1:0] wdata;
  logic                   done;
  logic [IRDP_DATA_W-1:0] rdata;
  modport bank (output req, wr, tgt, addr, wdata, input done, rdata);
  modport mux  (input req, wr, tgt, addr, wdata, output done, rdata);
endinterface : irdp_ram_if

// *** irdp_ram_mux.sv ***
// routes one port access to the selected internal ram; reserved targets complete at once
module irdp_ram_mux
  import irdp_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  irdp_ram_if.mux                     bus,
  output logic [7:0]                  ram_req,
  output logic                        ram_wr,
  output logic [IRDP_ADDR_W-1:0]      ram_addr,
  output logic [IRDP_DATA_W-1:0]      ram_wdata,
  input  wire logic [7:0]             ram_ack,
  input  wire logic [8*IRDP_DATA_W-1:0] ram_rdata
);
  logic tgt_valid;
  logic [2:0] idx;

  // decode target; codes 6 and 8..15 are reserved
  always_comb begin
    idx       = bus.tgt[2:0];
    tgt_valid = (bus.tgt[3] == 1'b0) && (bus.tgt != 4'h6);
  end

  // one-hot strobe toward the selected ram
  always_comb begin
    ram_req = 8'h00;
    if (bus.req && tgt_valid) begin
      ram_req[idx] = 1'b1;
    end
  end

  assign ram_wr    = bus.wr;
  assign ram_addr  = bus.addr;
  assign ram_wdata = bus.wdata;
  // reserved targets answer immediately with zero so the port never hangs
  assign bus.done  = bus.req && (tgt_valid ? ram_ack[idx] : 1'b1);
  assign bus.rdata = tgt_valid ? ram_rdata[idx*IRDP_DATA_W +: IRDP_DATA_W] : IRDP_UNMAPPED;

  hold_stable_a: assert property (@(posedge core_clk) disable iff (rst)
    bus.req && !bus.done && clk_en |=> $stable(bus.addr) && $stable(bus.wr) && bus.req)
    else $error("ram request dropped early");
endmodule : irdp_ram_mux
